/* logic/sampler_pkg.sv */
package sampler_pkg;

    // clock and time base
    localparam int CLK_NS         = 10;
    localparam int TICK_NS        = 500000;
    localparam int TICK_CYCLES    = TICK_NS / CLK_NS;
    localparam int REFRESH_NS     = 1000000;
    localparam int REFRESH_CYCLES = REFRESH_NS / CLK_NS;

    // terminals per module
    localparam int TERMS = 10;

    // register indices as printed, byte address is four times the index
    localparam logic [15:0] IDX_WORD0  = 16'h0b90;
    localparam logic [15:0] IDX_WORD1  = 16'h0b92;
    localparam logic [15:0] ADDR_WORD0 = {IDX_WORD0[13:0], 2'b00};
    localparam logic [15:0] ADDR_WORD1 = {IDX_WORD1[13:0], 2'b00};
    localparam logic [15:0] ADDR_CFG   = 16'h0000;
    localparam logic [15:0] ADDR_FUNC0 = 16'h0004;
    localparam logic [15:0] ADDR_OWN1  = 16'h0008;

    // filter setting field
    localparam int         FILT_LSB   = 0;
    localparam int         FILT_W     = 3;
    localparam logic [2:0] FILT_RESET = 3'h5;

    // function fields of module zero, terminals 0..5, three bits each
    localparam int          FUNC_W     = 3;
    localparam int          FUNC_TERMS = 6;
    localparam logic [17:0] FUNC_RESET = 18'h00000;
    localparam logic [9:0]  OWN1_RESET = 10'h000;

    // function codes
    localparam logic [2:0] FN_NORMAL   = 3'h0;
    localparam logic [2:0] FN_QUICK    = 3'h1;
    localparam logic [2:0] FN_IRQ      = 3'h2;
    localparam logic [2:0] FN_CNT_Z    = 3'h3;
    localparam logic [2:0] FN_ORIGIN   = 3'h4;
    localparam logic [2:0] FN_PROX     = 3'h5;
    localparam logic [2:0] FN_POS_DONE = 3'h6;

    // bus
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
    } ahb_req_s;

endpackage

/* logic/filtered_input_sampler.sv */
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module filtered_input_sampler #(
    parameter int TICK_CYCLES    = sampler_pkg::TICK_CYCLES,
    parameter int REFRESH_CYCLES = sampler_pkg::REFRESH_CYCLES
) (
    input  wire logic        hclk,           // bus clock
    input  wire logic        hresetn,        // async reset, low
    input  wire logic        hsel,           // slave select
    input  wire logic [31:0] haddr,          // byte address
    input  wire logic [1:0]  htrans,         // transfer type
    input  wire logic        hwrite,         // write access
    input  wire logic [2:0]  hsize,          // transfer size
    input  wire logic [31:0] hwdata,         // write data
    input  wire logic        hready,         // bus ready
    output logic             hreadyout,      // slave ready
    output logic             hresp,          // always okay
    output logic      [31:0] hrdata,         // read data
    input  wire logic [9:0]  terminals_zero, // module zero pins
    input  wire logic [9:0]  terminals_one,  // module one pins
    output logic      [19:0] alt_level,      // filtered, alternate use
    output logic      [17:0] func_code       // module zero functions
);

    localparam int N = 2 * sampler_pkg::TERMS;

    // refuse periods the dividers cannot serve
    if (TICK_CYCLES < 2 || REFRESH_CYCLES < 2) begin : g_bad_period
        $error("tick and refresh periods must be two cycles or more");
    end

    // code to filter length in ticks of 0.5 ms
    function automatic logic [6:0] filt_ticks(input logic [2:0] code);
        filt_ticks = (code == 3'h0) ? 7'h00 : 7'(7'h01 << (code - 3'h1));
    endfunction

    // function code allowed on module zero terminal
    function automatic logic func_legal(input int t, input logic [2:0] c);
        logic ok;
        ok = (c == sampler_pkg::FN_NORMAL);
        case (t)
            0: ok = ok | c == sampler_pkg::FN_QUICK | c == sampler_pkg::FN_IRQ
                       | c == sampler_pkg::FN_ORIGIN;
            1: ok = ok | c == sampler_pkg::FN_QUICK | c == sampler_pkg::FN_IRQ
                       | c == sampler_pkg::FN_PROX;
            2: ok = ok | c == sampler_pkg::FN_QUICK | c == sampler_pkg::FN_IRQ
                       | c == sampler_pkg::FN_CNT_Z
                       | c == sampler_pkg::FN_ORIGIN;
            3: ok = ok | c == sampler_pkg::FN_QUICK | c == sampler_pkg::FN_IRQ
                       | c == sampler_pkg::FN_CNT_Z
                       | c == sampler_pkg::FN_PROX;
            4, 5: ok = ok | c == sampler_pkg::FN_POS_DONE;
            default: ok = 1'b0;
        endcase
        func_legal = ok;
    endfunction

    logic [N-1:0]  sync1_reg;
    logic [N-1:0]  sync2_reg;
    logic [N-1:0]  filt_reg;
    logic [6:0]    cnt_reg [N];
    logic [31:0]   tick_cnt_reg;
    logic [31:0]   ref_cnt_reg;
    logic          tick_reg;
    logic          refresh_reg;
    logic [2:0]    filt_code_reg;
    logic [17:0]   func_reg;
    logic [17:0]   func_next;
    logic [9:0]    own1_reg;
    logic [9:0]    word0_reg;
    logic [9:0]    word1_reg;
    sampler_pkg::ahb_req_s req_reg;

    // bus decode
    wire        addr_ok  = hsel && hready
                           && htrans == sampler_pkg::HTRANS_NONSEQ
                           && hsize == sampler_pkg::HSIZE_WORD
                           && haddr[31:16] == 16'h0000;
    wire [15:0] a        = haddr[15:0];
    wire        wr_cfg   = req_reg.valid && req_reg.write
                           && req_reg.addr == sampler_pkg::ADDR_CFG;
    wire        wr_func  = req_reg.valid && req_reg.write
                           && req_reg.addr == sampler_pkg::ADDR_FUNC0;
    wire        wr_own1  = req_reg.valid && req_reg.write
                           && req_reg.addr == sampler_pkg::ADDR_OWN1;
    wire [6:0]  limit    = filt_ticks(filt_code_reg);

    // ownership masks, nonzero function code takes the terminal
    wire [9:0]  own0;
    assign own0[9:6] = 4'h0;
    for (genvar t = 0; t < sampler_pkg::FUNC_TERMS; t++) begin : g_own
        assign own0[t] = func_reg[3*t +: 3] != sampler_pkg::FN_NORMAL;
    end
    wire [N-1:0] own_all = {own1_reg, own0};

    wire [31:0] rd_mux =
        (a == sampler_pkg::ADDR_WORD0) ? {22'h0, word0_reg} :
        (a == sampler_pkg::ADDR_WORD1) ? {22'h0, word1_reg} :
        (a == sampler_pkg::ADDR_CFG)   ? {29'h0, filt_code_reg} :
        (a == sampler_pkg::ADDR_FUNC0) ? {14'h0, func_reg} :
        (a == sampler_pkg::ADDR_OWN1)  ? {22'h0, own1_reg} : 32'h0;

    always_comb begin
        func_next = func_reg;
        for (int t = 0; t < sampler_pkg::FUNC_TERMS; t++) begin
            func_next[3*t +: 3] = func_legal(t, hwdata[3*t +: 3])
                                  ? hwdata[3*t +: 3] : sampler_pkg::FN_NORMAL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_reg   <= '0;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            req_reg   <= '{valid: addr_ok, write: hwrite, addr: a};
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // reset to all-normal and 8 ms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_code_reg <= sampler_pkg::FILT_RESET;
            func_reg      <= sampler_pkg::FUNC_RESET;
            own1_reg      <= sampler_pkg::OWN1_RESET;
        end else begin
            if (wr_cfg) begin
                filt_code_reg <= hwdata[sampler_pkg::FILT_LSB +: 3];
            end
            if (wr_func) begin
                func_reg <= func_next;
            end
            if (wr_own1) begin
                own1_reg <= hwdata[9:0];
            end
        end
    end

    // tick and refresh dividers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= 32'h0;
            ref_cnt_reg  <= 32'h0;
            tick_reg     <= 1'b0;
            refresh_reg  <= 1'b0;
        end else begin
            tick_reg    <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
            refresh_reg <= ref_cnt_reg == 32'(REFRESH_CYCLES - 1);
            tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYCLES - 1))
                            ? 32'h0 : tick_cnt_reg + 32'h1;
            ref_cnt_reg  <= (ref_cnt_reg == 32'(REFRESH_CYCLES - 1))
                            ? 32'h0 : ref_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {terminals_one, terminals_zero};
            sync2_reg <= sync1_reg;
        end
    end

    // level must hold for limit ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_reg <= '0;
            for (int i = 0; i < N; i++) begin
                cnt_reg[i] <= 7'h00;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (sync2_reg[i] == filt_reg[i]) begin
                    cnt_reg[i] <= 7'h00;
                end else if (limit == 7'h00) begin
                    filt_reg[i] <= sync2_reg[i];
                end else if (tick_reg) begin
                    if (cnt_reg[i] == limit) begin
                        filt_reg[i] <= sync2_reg[i];
                        cnt_reg[i]  <= 7'h00;
                    end else begin
                        cnt_reg[i] <= cnt_reg[i] + 7'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word0_reg <= 10'h000;
            word1_reg <= 10'h000;
            alt_level <= 20'h00000;
        end else begin
            alt_level <= filt_reg & own_all;
            if (refresh_reg) begin
                word0_reg <= filt_reg[9:0] & ~own0;
                word1_reg <= filt_reg[19:10] & ~own1_reg;
            end
        end
    end

    assign func_code = func_reg;

    // checks
    logic first_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // halves of the filtered level for the refresh checks
    wire [9:0] filt_zero = filt_reg[9:0];
    wire [9:0] filt_one  = filt_reg[19:10];

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // status words
    AST_REFRESH_SAMPLES: assert property (
        refresh_reg |=> word1_reg == ($past(filt_one) & ~$past(own1_reg)))
        else $error("module one word missed refresh sample");
    AST_WORD0_SAMPLES: assert property (
        refresh_reg |=> word0_reg == ($past(filt_zero) & ~$past(own0)))
        else $error("module zero word missed refresh sample");
    AST_WORDS_HOLD: assert property (
        !refresh_reg |=> $stable(word0_reg) && $stable(word1_reg))
        else $error("status word changed outside a refresh");

    // bus answers
    AST_WORD_READ: assert property (
        addr_ok && !hwrite && a == sampler_pkg::ADDR_WORD0
        |=> hrdata == {22'h0, $past(word0_reg)})
        else $error("word 2960 read returned wrong data");
    AST_HRDATA_HOLD: assert property (
        !(addr_ok && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");
    AST_CFG_WRITE: assert property (
        wr_cfg |=> filt_code_reg == 3'($past(hwdata)))
        else $error("filter setting write did not land");

    // configuration and filter
    AST_ALT_FROM_CFG: assert property (
        ##1 (alt_level & ~$past(own_all)) == 20'h0)
        else $error("alternate level leaked on normal terminal");
    AST_RESET_NORMAL: assert property (
        first_q |-> func_reg == 18'h0 && own1_reg == 10'h0
                    && filt_code_reg == sampler_pkg::FILT_RESET)
        else $error("reset configuration not default");
    AST_UNFILTERED: assert property (
        limit == 7'h00 |=> filt_reg == $past(sync2_reg))
        else $error("unfiltered setting did not pass level");
    AST_FILTER_HOLD: assert property (
        !tick_reg && limit != 7'h00 |=> $stable(filt_reg))
        else $error("filter changed between ticks");
    AST_OWN_MASKED: assert property (
        refresh_reg |=> (word0_reg & $past(own0)) == 10'h0)
        else $error("owned terminal seen as normal input");
    AST_OWN1_MASKED: assert property (
        refresh_reg |=> (word1_reg & $past(own1_reg)) == 10'h0)
        else $error("owned module one terminal seen as normal input");
    AST_FUNC_LEGAL: assert property (
        func_legal(0, func_reg[2:0]) && func_legal(1, func_reg[5:3])
        && func_legal(2, func_reg[8:6]) && func_legal(3, func_reg[11:9])
        && func_legal(4, func_reg[14:12]) && func_legal(5, func_reg[17:15]))
        else $error("illegal alternate function stored");

    COV_REFRESH_HIGH: cover property (refresh_reg ##1 word0_reg != 10'h0);
    COV_FILT_32MS: cover property (filt_code_reg == 3'h7 && tick_reg);
    COV_ALT_TAKEN: cover property (own0[2] ##1 alt_level[2]);
    COV_UNFILTERED: cover property (limit == 7'h00 ##1 refresh_reg);

endmodule

/* verification/field_sensors.sv */
`timescale 1ns/1ns
module field_sensors (
    input  wire logic        hclk,           // sampling clock
    input  wire logic [19:0] level,          // wanted field levels
    output logic      [9:0]  terminals_zero, // module zero pins
    output logic      [9:0]  terminals_one   // module one pins
);
    // contacts settle just after an edge, never on it
    always @(posedge hclk) begin
        terminals_zero <= level[9:0];
        terminals_one  <= level[19:10];
    end
endmodule

/* verification/test_filtered_input_sampler.sv */
`timescale 1ns/1ns
module test_filtered_input_sampler;
    localparam int          TK   = 4;
    localparam int          RF   = 8;
    localparam logic [15:0] CFG  = sampler_pkg::ADDR_CFG;
    localparam logic [15:0] FN0  = sampler_pkg::ADDR_FUNC0;
    localparam logic [15:0] OWN1 = sampler_pkg::ADDR_OWN1;
    localparam logic [15:0] W0   = sampler_pkg::ADDR_WORD0;
    localparam logic [15:0] W1   = sampler_pkg::ADDR_WORD1;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  tz;
    logic [9:0]  to;
    logic [19:0] alt_level;
    logic [19:0] level = 20'h0;
    logic [17:0] func_code;
    logic [7:0]  ok [6] = '{8'h17, 8'h27, 8'h1f, 8'h2f, 8'h41, 8'h41};
    int          err_total = 0;
    int          compares = 0;
    int          n;
    logic [2:0]  sz = 3'h2;
    logic [31:0] fx;
    always #5 hclk = ~hclk;

    field_sensors sensors (.hclk(hclk), .level(level),
        .terminals_zero(tz), .terminals_one(to));
    filtered_input_sampler #(.TICK_CYCLES(TK), .REFRESH_CYCLES(RF)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .terminals_zero(tz), .terminals_one(to),
        .alt_level(alt_level), .func_code(func_code));

    task end_of_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer of size sz, address phase then data phase
    task bus(input logic w, input logic [15:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {16'h0, a};
        htrans <= sampler_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task words(input logic [19:0] v);
        rdchk(W0, {22'h0, v[9:0]});
        rdchk(W1, {22'h0, v[19:10]});
    endtask
    task wt(input int c);
        repeat (c) @(posedge hclk);
    endtask

    initial begin
        wt(20000);
        err_total++;
        end_of_test;
    end

    initial begin
        wt(5);
        hresetn <= 1'b1;
        wt(1);
        rdchk(CFG, 32'h5);
        rdchk(FN0, 32'h0);
        rdchk(OWN1, 32'h0);
        chk({14'h0, func_code}, 32'h0);
        rdchk(16'h0100, 32'h0);
        // unfiltered path, then a write to a read-only word
        bus(1'b1, CFG, 32'h0);
        level <= 20'h2a5c3;
        wt(RF + 6);
        words(level);
        bus(1'b1, W0, 32'h0);
        words(level);
        // every filter time: new level after it, old level early from code 2 on
        for (int c = 1; c < 8; c++) begin
            n = TK << (c - 1);
            bus(1'b1, CFG, 32'(c));
            level <= ~level;
            if (c > 1) begin
                wt(n - TK - 2);
                words(~level);
            end
            wt(n + TK + RF + 4);
            words(level);
        end
        bus(1'b1, CFG, 32'h0);
        // allowed and refused function codes per terminal
        for (int t = 0; t < 6; t++) begin
            for (int c = 0; c < 8; c++) begin
                bus(1'b1, FN0, 32'(c) << (3 * t));
                fx = ok[t][c] ? 32'(c) << (3 * t) : 32'h0;
                rdchk(FN0, fx);
                chk({14'h0, func_code}, fx);
            end
        end
        // alternate owners drop out of the status words
        bus(1'b1, FN0, (32'(sampler_pkg::FN_QUICK) << 3)
                       | (32'(sampler_pkg::FN_POS_DONE) << 12));
        bus(1'b1, OWN1, 32'h200);
        level <= 20'hfffff;
        wt(RF + 6);
        words({10'h1ff, 10'h3ed});
        chk({12'h0, alt_level}, 32'h80012);
        rdchk(OWN1, 32'h200);
        bus(1'b1, FN0, 32'h0);
        bus(1'b1, OWN1, 32'h0);
        wt(RF + 6);
        words(level);
        chk({12'h0, alt_level}, 32'h0);
        // second reset restores defaults and the 8 ms filter
        bus(1'b1, CFG, 32'h7);
        bus(1'b1, FN0, 32'h1);
        hresetn <= 1'b0;
        wt(2);
        hresetn <= 1'b1;
        wt(1);
        // a byte-sized write is refused
        sz = 3'h0;
        bus(1'b1, CFG, 32'h3);
        sz = sampler_pkg::HSIZE_WORD;
        rdchk(CFG, 32'h5);
        rdchk(FN0, 32'h0);
        chk({14'h0, func_code}, 32'h0);
        wt(38);
        words(20'h0);
        wt(17 * TK + RF + 4);
        words(level);
        chk({31'h0, hresp}, 32'h0);
        end_of_test;
    end
endmodule
